// ==== aes_ecb_pkg.sv ====
package aes_ecb_pkg;
    // Round and key setting length in clock cycles
    localparam logic [3:0] ROUNDS = 4'hA;
    localparam logic [3:0] LAST_ROUND = ROUNDS - 4'h1;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] KEY_OFFSET = 8'h10;
    localparam logic [7:0] BLOCK_OFFSET = 8'h20;
    localparam logic [7:0] ENC_RES_OFFSET = 8'h30;
    localparam logic [7:0] DEC_RES_OFFSET = 8'h40;
    // Control bits (write one to pulse) and status bits
    localparam int ENC_KEY_BIT = 0;
    localparam int ENC_START_BIT = 1;
    localparam int DEC_KEY_BIT = 2;
    localparam int DEC_START_BIT = 3;
    localparam int STATUS_W = 4;
    // Reset values
    localparam logic [127:0] KEY_RESET = 128'h0;
    localparam logic [127:0] BLOCK_RESET = 128'h0;
    // AES field constants
    localparam logic [7:0] POLY_LOW = 8'h1B;
    localparam logic [7:0] INV_EXP = 8'hFE;
    localparam logic [7:0] AFFINE_C = 8'h63;
    localparam logic [7:0] INV_AFFINE_C = 8'h05;
    // Engine phases
    typedef enum logic [1:0] {IDLE, KEYSET, CRYPT} phase_type;
endpackage

// ==== aes_ecb_block_cipher.sv ====
`timescale 1ns/1ps

module aes_ecb_round_engine #(
    parameter bit DECRYPT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Key setting
    input wire logic key_load_strobe,
    input wire logic [127:0] key_value,
    output logic key_expand_busy,
    output logic key_expand_done,
    // Block processing
    input wire logic start_strobe,
    input wire logic [127:0] block_in,
    output logic busy,
    output logic done,
    output logic result_valid,
    output logic [127:0] result
);
    ////////////////////////////////////////////////////////////////////////
    // Field arithmetic
    function automatic logic [7:0] xt(input logic [7:0] b);
        return {b[6:0], 1'b0} ^ (b[7] ? aes_ecb_pkg::POLY_LOW : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a,
                                        input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = xt(x);
        end
        return p;
    endfunction

    // Multiplicative inverse as a^254, zero maps to zero
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 7; i >= 0; i--) begin
            r = gmul(r, r);
            if (aes_ecb_pkg::INV_EXP[i]) r = gmul(r, a);
        end
        return r;
    endfunction

    function automatic logic [7:0] rl(input logic [7:0] b, input int n);
        logic [15:0] t;
        t = {b, b} << n;
        return t[15:8];
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] b);
        logic [7:0] i;
        i = ginv(b);
        return i ^ rl(i, 1) ^ rl(i, 2) ^ rl(i, 3) ^ rl(i, 4)
            ^ aes_ecb_pkg::AFFINE_C;
    endfunction

    function automatic logic [7:0] isbox(input logic [7:0] b);
        return ginv(rl(b, 1) ^ rl(b, 3) ^ rl(b, 6)
            ^ aes_ecb_pkg::INV_AFFINE_C);
    endfunction

    function automatic logic [31:0] sub_rot(input logic [31:0] w);
        return {sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0]),
            sbox(w[31:24])};
    endfunction

    // Round constant of key round r (1..10)
    function automatic logic [7:0] rcon(input logic [3:0] r);
        logic [7:0] x;
        x = 8'h01;
        for (int i = 2; i <= 10; i++) begin
            if (i <= int'(r)) x = xt(x);
        end
        return x;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Key schedule steps, forward and backward
    function automatic logic [127:0] key_fwd(input logic [127:0] k,
                                             input logic [7:0] rc);
        logic [31:0] n0;
        logic [31:0] n1;
        logic [31:0] n2;
        n0 = k[127:96] ^ sub_rot(k[31:0]) ^ {rc, 24'h000000};
        n1 = k[95:64] ^ n0;
        n2 = k[63:32] ^ n1;
        return {n0, n1, n2, k[31:0] ^ n2};
    endfunction

    function automatic logic [127:0] key_inv(input logic [127:0] k,
                                             input logic [7:0] rc);
        logic [31:0] p3;
        p3 = k[31:0] ^ k[63:32];
        return {k[127:96] ^ sub_rot(p3) ^ {rc, 24'h000000},
            k[95:64] ^ k[127:96], k[63:32] ^ k[95:64], p3};
    endfunction

    // Column mixing with coefficients 2,3,1,1 or E,B,D,9
    function automatic logic [127:0] mix(input logic [127:0] s,
                                         input logic inv);
        logic [7:0] c [4];
        logic [7:0] a [4];
        logic [127:0] o;
        o = s;
        c[0] = inv ? 8'h0E : 8'h02;
        c[1] = inv ? 8'h0B : 8'h03;
        c[2] = inv ? 8'h0D : 8'h01;
        c[3] = inv ? 8'h09 : 8'h01;
        for (int col = 0; col < 4; col++) begin
            for (int r = 0; r < 4; r++) a[r] = s[127-8*(4*col+r) -: 8];
            for (int r = 0; r < 4; r++) begin
                o[127-8*(4*col+r) -: 8] = gmul(a[r], c[0])
                    ^ gmul(a[(r+1)%4], c[1]) ^ gmul(a[(r+2)%4], c[2])
                    ^ gmul(a[(r+3)%4], c[3]);
            end
        end
        return o;
    endfunction

    // One cipher round in either direction
    function automatic logic [127:0] round(input logic [127:0] s,
                                           input logic [127:0] rk,
                                           input logic last,
                                           input logic inv);
        logic [127:0] t;
        int src;
        t = s;
        for (int n = 0; n < 16; n++) begin
            src = inv ? 4 * (((n / 4) + 4 - (n % 4)) % 4) + (n % 4)
                : 4 * (((n / 4) + (n % 4)) % 4) + (n % 4);
            t[127-8*n -: 8] = inv ? isbox(s[127-8*src -: 8])
                : sbox(s[127-8*src -: 8]);
        end
        if (inv) t = t ^ rk;
        if (!last) t = mix(t, inv);
        if (!inv) t = t ^ rk;
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    aes_ecb_pkg::phase_type phase_ff;
    logic [3:0] cnt_ff;
    logic [127:0] key_ff;
    logic [127:0] work_ff;
    logic [127:0] state_ff;
    logic [127:0] result_ff;
    logic valid_ff;
    logic last;
    logic [3:0] key_round;
    logic [127:0] nxt_rk;

    assign last = cnt_ff == aes_ecb_pkg::LAST_ROUND;
    assign key_expand_busy = phase_ff == aes_ecb_pkg::KEYSET;
    assign key_expand_done = key_expand_busy && last;
    assign busy = phase_ff == aes_ecb_pkg::CRYPT;
    assign done = busy && last;
    assign result_valid = valid_ff;
    assign result = result_ff;

    // Next round key: backward while decrypting, forward otherwise
    always_comb begin
        key_round = (DECRYPT && busy) ? aes_ecb_pkg::ROUNDS - cnt_ff
            : cnt_ff + 4'h1;
        nxt_rk = (DECRYPT && busy) ? key_inv(work_ff, rcon(key_round))
            : key_fwd(work_ff, rcon(key_round));
    end

    // Phase and cycle counter; strobes honoured only when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= aes_ecb_pkg::IDLE;
            cnt_ff <= 4'h0;
        end else begin
            unique case (phase_ff)
                aes_ecb_pkg::IDLE: begin
                    cnt_ff <= 4'h0;
                    if (key_load_strobe) begin
                        phase_ff <= aes_ecb_pkg::KEYSET;
                    end else if (start_strobe) begin
                        phase_ff <= aes_ecb_pkg::CRYPT;
                    end
                end
                aes_ecb_pkg::KEYSET, aes_ecb_pkg::CRYPT: begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (last) begin
                        phase_ff <= aes_ecb_pkg::IDLE;
                        cnt_ff <= 4'h0;
                    end
                end
            endcase
        end
    end

    // Key store: original key for encrypt, last round key for decrypt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_ff <= aes_ecb_pkg::KEY_RESET;
            work_ff <= aes_ecb_pkg::KEY_RESET;
        end else if (phase_ff == aes_ecb_pkg::IDLE) begin
            if (key_load_strobe) begin
                key_ff <= key_value;
                work_ff <= key_value;
            end else if (start_strobe) begin
                work_ff <= key_ff;
            end
        end else begin
            work_ff <= nxt_rk;
            if (DECRYPT && key_expand_done) key_ff <= nxt_rk;
        end
    end

    // Data path, one round per busy cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= aes_ecb_pkg::BLOCK_RESET;
        end else if (phase_ff == aes_ecb_pkg::IDLE) begin
            if (!key_load_strobe && start_strobe) begin
                state_ff <= block_in ^ key_ff;
            end
        end else if (busy) begin
            state_ff <= round(state_ff, nxt_rk, last, DECRYPT);
        end
    end

    // Result register and single-cycle valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= aes_ecb_pkg::BLOCK_RESET;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= done;
            if (done) begin
                result_ff <= round(state_ff, nxt_rk, last, DECRYPT);
            end
        end
    end
endmodule // aes_ecb_round_engine

////////////////////////////////////////////////////////////////////////////

module aes_ecb_block_cipher (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Encryption status
    output logic enc_key_expand_busy,
    output logic enc_key_expand_done,
    output logic enc_busy,
    output logic enc_done,
    output logic enc_result_valid,
    output logic [127:0] enc_result,
    // Decryption status
    output logic dec_key_expand_busy,
    output logic dec_key_expand_done,
    output logic dec_busy,
    output logic dec_done,
    output logic dec_result_valid,
    output logic [127:0] dec_result
);
    logic dp_valid_ff;
    logic dp_write_ff;
    logic [7:0] dp_addr_ff;
    logic [127:0] key_value_ff;
    logic [127:0] block_word_ff;
    logic ctrl_wr;
    logic [1:0] widx;
    logic [7:0] region;
    logic [aes_ecb_pkg::STATUS_W-1:0] status;

    function automatic logic [31:0] word_of(input logic [127:0] v,
                                            input logic [1:0] i);
        return v[127-32*i -: 32];
    endfunction

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign widx = dp_addr_ff[3:2];
    assign region = {dp_addr_ff[7:4], 4'h0};
    assign ctrl_wr = dp_valid_ff && dp_write_ff
        && dp_addr_ff == aes_ecb_pkg::CTRL_OFFSET;
    assign status = {dec_busy, dec_key_expand_busy, enc_busy,
        enc_key_expand_busy};

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
        end else if (hready) begin
            dp_valid_ff <= hsel && htrans[1];
            dp_write_ff <= hwrite;
            dp_addr_ff <= haddr[7:0];
        end
    end

    // Key and input block words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_value_ff <= aes_ecb_pkg::KEY_RESET;
            block_word_ff <= aes_ecb_pkg::BLOCK_RESET;
        end else if (dp_valid_ff && dp_write_ff) begin
            if (region == aes_ecb_pkg::KEY_OFFSET) begin
                key_value_ff[127-32*widx -: 32] <= hwdata;
            end
            if (region == aes_ecb_pkg::BLOCK_OFFSET) begin
                block_word_ff[127-32*widx -: 32] <= hwdata;
            end
        end
    end

    // Read data in the data phase, zero for unmapped addresses
    always_comb begin
        hrdata = 32'h00000000;
        if (dp_valid_ff && !dp_write_ff) begin
            if (dp_addr_ff == aes_ecb_pkg::STATUS_OFFSET) begin
                hrdata = {28'h0000000, status};
            end else if (region == aes_ecb_pkg::KEY_OFFSET) begin
                hrdata = word_of(key_value_ff, widx);
            end else if (region == aes_ecb_pkg::BLOCK_OFFSET) begin
                hrdata = word_of(block_word_ff, widx);
            end else if (region == aes_ecb_pkg::ENC_RES_OFFSET) begin
                hrdata = word_of(enc_result, widx);
            end else if (region == aes_ecb_pkg::DEC_RES_OFFSET) begin
                hrdata = word_of(dec_result, widx);
            end
        end
    end

    aes_ecb_round_engine #(.DECRYPT(1'b0)) u_enc (
        .clk(hclk),
        .rst_n(hresetn),
        .key_load_strobe(ctrl_wr && hwdata[aes_ecb_pkg::ENC_KEY_BIT]),
        .key_value(key_value_ff),
        .key_expand_busy(enc_key_expand_busy),
        .key_expand_done(enc_key_expand_done),
        .start_strobe(ctrl_wr && hwdata[aes_ecb_pkg::ENC_START_BIT]),
        .block_in(block_word_ff),
        .busy(enc_busy),
        .done(enc_done),
        .result_valid(enc_result_valid),
        .result(enc_result)
    );

    aes_ecb_round_engine #(.DECRYPT(1'b1)) u_dec (
        .clk(hclk),
        .rst_n(hresetn),
        .key_load_strobe(ctrl_wr && hwdata[aes_ecb_pkg::DEC_KEY_BIT]),
        .key_value(key_value_ff),
        .key_expand_busy(dec_key_expand_busy),
        .key_expand_done(dec_key_expand_done),
        .start_strobe(ctrl_wr && hwdata[aes_ecb_pkg::DEC_START_BIT]),
        .block_in(block_word_ff),
        .busy(dec_busy),
        .done(dec_done),
        .result_valid(dec_result_valid),
        .result(dec_result)
    );
endmodule // aes_ecb_block_cipher

// ==== aes_ecb_props.sv ====
`timescale 1ns/1ps
module aes_ecb_props (
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Engine status
    input wire logic enc_key_expand_busy,
    input wire logic enc_key_expand_done,
    input wire logic enc_busy,
    input wire logic enc_done,
    input wire logic enc_result_valid,
    input wire logic [127:0] enc_result,
    input wire logic dec_key_expand_busy,
    input wire logic dec_key_expand_done,
    input wire logic dec_busy,
    input wire logic dec_done,
    input wire logic dec_result_valid,
    input wire logic [127:0] dec_result
);
    logic ctrl_wr_ff;
    logic enc_idle, dec_idle, enc_key_go, enc_go, dec_key_go, dec_go;
    // Control write seen in its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_wr_ff <= 1'b0;
        end else begin
            ctrl_wr_ff <= hsel && hready && htrans[1] && hwrite
                && haddr[7:0] == aes_ecb_pkg::CTRL_OFFSET;
        end
    end
    // Strobes that an idle engine must take; key load wins over start
    assign enc_idle = !enc_busy && !enc_key_expand_busy;
    assign dec_idle = !dec_busy && !dec_key_expand_busy;
    assign enc_key_go = ctrl_wr_ff && hwdata[0] && enc_idle;
    assign enc_go = ctrl_wr_ff && hwdata[1] && !hwdata[0] && enc_idle;
    assign dec_key_go = ctrl_wr_ff && hwdata[2] && dec_idle;
    assign dec_go = ctrl_wr_ff && hwdata[3] && !hwdata[2] && dec_idle;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    // Busy for ten cycles from the cycle after the strobe, done on the last
    property run_p(logic go, logic b, logic d);
        go |=> b [*8] ##1 b ##1 (b && d) ##1 !b;
    endproperty
    a_enc_key_run: assert property (
        run_p(enc_key_go, enc_key_expand_busy, enc_key_expand_done))
        else $error("encrypt key setting timing wrong");
    a_enc_run_len: assert property (run_p(enc_go, enc_busy, enc_done))
        else $error("encrypt busy timing wrong");
    a_dec_key_run: assert property (
        run_p(dec_key_go, dec_key_expand_busy, dec_key_expand_done))
        else $error("decrypt key setting timing wrong");
    a_dec_run_len: assert property (run_p(dec_go, dec_busy, dec_done))
        else $error("decrypt busy timing wrong");
    a_enc_strobe_ignored: assert property (
        ctrl_wr_ff && !enc_idle |=> !$rose(enc_busy)
        && !$rose(enc_key_expand_busy))
        else $error("encrypt engine took a strobe while busy");
    a_dec_strobe_ignored: assert property (
        ctrl_wr_ff && !dec_idle |=> !$rose(dec_busy)
        && !$rose(dec_key_expand_busy))
        else $error("decrypt engine took a strobe while busy");
    a_enc_valid_pulse: assert property (
        enc_done |=> enc_result_valid ##1 !enc_result_valid)
        else $error("encrypt result valid not one pulse after done");
    a_dec_valid_pulse: assert property (
        dec_done |=> dec_result_valid ##1 !dec_result_valid)
        else $error("decrypt result valid not one pulse after done");
    a_results_held: assert property (
        !enc_result_valid && !dec_result_valid
        |-> $stable(enc_result) && $stable(dec_result))
        else $error("result changed without valid");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");

    // Main scenarios reached
    c_enc_back_to_back: cover property (enc_done ##2 enc_busy);
    c_dec_back_to_back: cover property (dec_done ##2 dec_busy);
    c_strobe_in_busy: cover property (ctrl_wr_ff && enc_busy && dec_busy);
endmodule // aes_ecb_props

bind aes_ecb_block_cipher aes_ecb_props u_aes_ecb_props (.*);

// ==== aes_user_master.sv ====
`timescale 1ns/1ps
module aes_user_master (
    // Clock
    input wire logic hclk,
    // Bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Bus answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // Idle bus, word size
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end
    // One single word transfer; call just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // Released data must not look like the last word
        hwdata <= ~d;
    endtask
    // Whole 128-bit value, high word first, before any strobe
    task automatic put128(input logic [7:0] a, input logic [127:0] v);
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, a + 8'(4 * i), v[127 - 32 * i -: 32], q);
        end
    endtask
    task automatic get128(input logic [7:0] a, output logic [127:0] v);
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, a + 8'(4 * i), 32'h0, q);
            v[127 - 32 * i -: 32] = q;
        end
    endtask
endmodule // aes_user_master

// ==== aes_ecb_block_cipher_tb.sv ====
`timescale 1ns/1ps
module aes_ecb_block_cipher_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic enc_key_expand_busy, enc_key_expand_done, enc_busy, enc_done;
    logic dec_key_expand_busy, dec_key_expand_done, dec_busy, dec_done;
    logic enc_result_valid, dec_result_valid;
    logic [127:0] enc_result, dec_result, v, x, y, z;
    logic [127:0] got_enc[$];
    logic [127:0] got_dec[$];
    logic [127:0] kv[2] = '{128'h000102030405060708090A0B0C0D0E0F,
                            128'h2B7E151628AED2A6ABF7158809CF4F3C};
    logic [127:0] pv[2] = '{128'h00112233445566778899AABBCCDDEEFF,
                            128'h3243F6A8885A308D313198A2E0370734};
    logic [127:0] cv[2] = '{128'h69C4E0D86A7B0430D8CDB78070B4C55A,
                            128'h3925841D02DC09FBDC118597196A0B32};
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h0E43;

    aes_ecb_block_cipher u_aes_ecb_block_cipher (.hready(hreadyout), .*);
    aes_user_master u_aes_user_master (.hready(hreadyout), .*);

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // Results collected as they are flagged; timeout
    always @(posedge hclk) begin
        if (hresetn && enc_result_valid === 1'b1) got_enc.push_back(enc_result);
        if (hresetn && dec_result_valid === 1'b1) got_dec.push_back(dec_result);
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_aes_user_master.xfer(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_aes_user_master.xfer(1'b0, a, 32'h0, q);
        chk(128'(q), 128'(exp));
    endtask
    // Bounded wait until every engine is idle and its valid has landed
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge hclk);
        while ((enc_busy | dec_busy | enc_key_expand_busy
                | dec_key_expand_busy) !== 1'b0 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        @(posedge hclk);
        chk(128'(n == 40), 128'h0);
    endtask
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(128'({enc_key_expand_busy, enc_busy, enc_result_valid,
                  dec_key_expand_busy, dec_busy, dec_result_valid}), 0);
        chk(enc_result | dec_result, 128'h0);
        // Key words read back; write-only and unmapped places read zero
        u_aes_user_master.put128(aes_ecb_pkg::KEY_OFFSET, kv[1]);
        u_aes_user_master.get128(aes_ecb_pkg::KEY_OFFSET, v);
        chk(v, kv[1]);
        rdchk(8'h80, 32'h0);
        rdchk(aes_ecb_pkg::CTRL_OFFSET, 32'h0);
        // Known vectors in both directions, starts refused during key setting
        for (int i = 0; i < 2; i++) begin
            u_aes_user_master.put128(aes_ecb_pkg::KEY_OFFSET, kv[i]);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h5);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'hA);
            rdchk(aes_ecb_pkg::STATUS_OFFSET, 32'h5);
            wait_idle();
            chk(128'(got_enc.size() + got_dec.size()), 0);
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, pv[i]);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h2);
            rdchk(aes_ecb_pkg::STATUS_OFFSET, 32'h2);
            wait_idle();
            chk(got_enc.pop_front(), cv[i]);
            u_aes_user_master.get128(aes_ecb_pkg::ENC_RES_OFFSET, v);
            chk(v, cv[i]);
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, cv[i]);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h8);
            rdchk(aes_ecb_pkg::STATUS_OFFSET, 32'h8);
            wait_idle();
            chk(got_dec.pop_front(), pv[i]);
            u_aes_user_master.get128(aes_ecb_pkg::DEC_RES_OFFSET, v);
            chk(v, pv[i]);
        end
        // Random blocks: key words changed without a load, loads while busy
        for (int r = 0; r < 3; r++) begin
            x = {$random(seed), $random(seed), $random(seed), $random(seed)};
            u_aes_user_master.put128(aes_ecb_pkg::KEY_OFFSET, ~x);
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, x);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'hA);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h5);
            wait_idle();
            chk(128'(got_enc.size() + got_dec.size()), 2);
            y = got_enc.pop_front();
            z = got_dec.pop_front();
            // Next start lands in the cycle after done
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, z);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h2);
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, x);
            @(posedge hclk);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h2);
            wait_idle();
            chk(got_enc.pop_front(), x);
            chk(got_enc.pop_front(), y);
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, y);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h8);
            u_aes_user_master.put128(aes_ecb_pkg::BLOCK_OFFSET, x);
            @(posedge hclk);
            wr(aes_ecb_pkg::CTRL_OFFSET, 32'h8);
            wait_idle();
            chk(got_dec.pop_front(), x);
            chk(got_dec.pop_front(), z);
        end
        chk(128'(got_enc.size() + got_dec.size()), 0);
        // Reset in mid-operation returns both engines to idle
        wr(aes_ecb_pkg::CTRL_OFFSET, 32'hA);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(128'({enc_busy, dec_busy, enc_result_valid,
                  dec_result_valid}), 0);
        chk(enc_result | dec_result, 128'h0);
        give_verdict();
    end
endmodule // aes_ecb_block_cipher_tb
